/* File: bench/bfs_supervisor_monitor.sv */
// checker on the supervisor ports, attached by bind
// assumes one system clock and the active-low asynchronous reset
`timescale 1ns/1ns
module bfs_supervisor_monitor (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic enable_in,
   input wire logic vin_ok,
   input wire logic softstart_done,
   input wire logic fb_below_80,
   input wire logic fb_above_104,
   input wire logic fb_above_116,
   input wire logic il_above_valley,
   input wire logic temp_above_160,
   input wire logic temp_cooled_30,
   input wire logic ton_request,
   input wire logic ls_request,
   input wire logic hs_on,
   input wire logic ls_on,
   input wire logic discharge_on,
   input wire logic power_good_flag_oe_n
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // six cycles cover two sync flops, the state edge and the output register
   a_valley_block: assert property ((il_above_valley && !hs_on)[*6] |=> !hs_on)
      else $error("high-side pulse started above valley limit");
   a_uvp_pg: assert property ((fb_below_80 && softstart_done)[*6] |->
      !power_good_flag_oe_n)
      else $error("power-good released during undervoltage");
   a_ovp_latch: assert property (fb_above_116[*6] |-> !hs_on && !power_good_flag_oe_n)
      else $error("high side or power-good wrong in overvoltage");
   a_qdm_hs_off: assert property (fb_above_104[*6] |-> !hs_on)
      else $error("high side on during quick discharge");
   a_otp_stop: assert property (temp_above_160[*6] |-> !hs_on && !ls_on && discharge_on)
      else $error("switching while overheated");
   a_disable_dis: assert property ((!enable_in)[*6] |-> discharge_on && !hs_on && !ls_on)
      else $error("no discharge while disabled");
   a_dis_release: assert property (
      (!enable_in && temp_cooled_30 && !temp_above_160)[*6] ##1
      (enable_in && vin_ok && temp_cooled_30 && !temp_above_160)[*8] |-> !discharge_on)
      else $error("discharge path held after enable returned");
   // a drop with the low side still requested is the pause or a stop of switching
   a_neg_pause: assert property ($fell(ls_on) && $past(ls_request) && !$past(ton_request)
      |-> (!ls_on)[*7])
      else $error("low-side pause shorter than seven cycles");
   c_ovp: cover property (fb_above_116[*8]);
   c_pause: cover property ($fell(ls_on) && !$past(ton_request));
   c_otp: cover property (temp_above_160 ##8 temp_cooled_30);
endmodule // bfs_supervisor_monitor

bind bfs_supervisor bfs_supervisor_monitor mon (
   .clk_sys, .resetn, .enable_in, .vin_ok, .softstart_done, .fb_below_80,
   .fb_above_104, .fb_above_116, .il_above_valley, .temp_above_160, .temp_cooled_30,
   .ton_request, .ls_request, .hs_on, .ls_on, .discharge_on, .power_good_flag_oe_n
);

/* File: bench/bfs_supervisor_test.sv */
// self-checking bench for the fault protection supervisor
// assumes a 10 MHz clock; hiccup windows shortened by parameter
`timescale 1ns/1ns
`include "bfs_regs.svh"
module bfs_supervisor_test;
   localparam int HOFF = 20;
   localparam int HON = 10;
   logic clk_sys = 0, resetn = 0, enable_in = 1, vin_ok = 1, softstart_done = 1;
   logic pg_window_ok = 1, fb_below_50 = 0, fb_below_80 = 0, fb_above_102 = 0;
   logic fb_above_104 = 0, fb_above_116 = 0, il_above_valley = 0, il_below_negative = 0;
   logic temp_above_160 = 0, temp_cooled_30 = 1, ton_request = 0, ls_request = 1;
   logic forced_continuous_conduction_cycle_done = 0, reg_wr = 0, reg_rd = 0;
   logic [`BFS_ADDR_W-1:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, d;
   logic irq, hs_on, ls_on, discharge_on, power_good_flag_out, power_good_flag_oe_n;
   int miscompares = 0, n_compared = 0, n;
   // bit4 irq, bit3 high side, bit2 low side, bit1 discharge, bit0 pg release
   wire [31:0] outs = {27'h0, irq, hs_on, ls_on, discharge_on, power_good_flag_oe_n};

   bfs_supervisor #(.HIC_OFF_CYC(HOFF), .HIC_ON_CYC(HON)) dut (
      .clk_sys, .resetn, .enable_in, .vin_ok, .softstart_done, .pg_window_ok,
      .fb_below_50, .fb_below_80, .fb_above_102, .fb_above_104, .fb_above_116,
      .il_above_valley, .il_below_negative, .temp_above_160, .temp_cooled_30,
      .ton_request, .ls_request, .forced_continuous_conduction_cycle_done, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .irq, .hs_on, .ls_on, .discharge_on,
      .power_good_flag_out, .power_good_flag_oe_n
   );

   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   // ends 1 ns after the edge so outputs have settled
   task step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   task chk(input string nm, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   task ob(input logic [31:0] m, e);
      chk("outs", outs & m, e);
   endtask

   task wr(input logic [3:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      step(1);
      reg_wr <= 1'h0;
      step(1);
   endtask

   task rd(input logic [3:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'h1;
      step(1);
      reg_rd <= 1'h0;
      chk("reg", reg_rdata, e);
      step(1);
   endtask

   // counts cycles the chosen switch command stays at level lv
   task runlen(input logic ls, input logic lv);
      n = 0;
      while (((ls ? ls_on : hs_on) === lv) && n < 999) begin
         n++;
         step(1);
      end
   endtask

   task neg;
      il_below_negative <= 1'h1;
      step(2);
      il_below_negative <= 1'h0;
   endtask

   task stop_test;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // whole sequence needs about 500 cycles
   initial begin
      repeat (6000) @(posedge clk_sys);
      miscompares++;
      stop_test;
   end

   initial begin
      void'($urandom(22574));
      step(16);
      resetn <= 1'h1;
      step(8);
      rd(`BFS_OFS_MASK, 32'h0);
      rd(`BFS_OFS_CTRL, 32'h3);
      rd(`BFS_OFS_STATE, 32'h2);
      rd(`BFS_OFS_STATUS, 32'h0);
      rd(4'h2, 32'h0);
      d = $urandom;
      wr(`BFS_OFS_MASK, d);
      rd(`BFS_OFS_MASK, d & 32'h3F);
      wr(`BFS_OFS_MASK, 32'h0);
      for (int i = 0; i < 2; i++) begin
         if (i == 0) enable_in <= 1'h0;
         else vin_ok <= 1'h0;
         step(10);
         ob(32'hF, 32'h2);
         enable_in <= 1'h1;
         vin_ok <= 1'h1;
         step(10);
         ob(32'hF, 32'h5);
      end
      neg;
      runlen(1, 1);
      runlen(1, 0);
      chk("pause", n, 32'h7);
      ls_request <= 1'h0;
      il_above_valley <= 1'h1;
      step(4);
      ton_request <= 1'h1;
      step(8);
      ob(32'h18, 32'h0);
      rd(`BFS_OFS_STATUS, 32'h30);
      wr(`BFS_OFS_MASK, 32'h20);
      step(2);
      ob(32'h10, 32'h10);
      il_above_valley <= 1'h0;
      step(8);
      ob(32'h8, 32'h8);
      wr(`BFS_OFS_STATUS, 32'h3F);
      step(2);
      ob(32'h10, 32'h0);
      rd(`BFS_OFS_STATUS, 32'h0);
      fb_below_80 <= 1'h1;
      runlen(0, 1);
      ob(32'h5, 32'h0);
      runlen(0, 0);
      chk("hic_off", n, HOFF);
      runlen(0, 1);
      chk("hic_on", n, HON);
      fb_below_80 <= 1'h0;
      runlen(0, 0);
      step(HON + 8);
      ob(32'h8, 32'h8);
      rd(`BFS_OFS_STATE, 32'h2);
      wr(`BFS_OFS_CTRL, 32'h1);
      rd(`BFS_OFS_CTRL, 32'h1);
      fb_below_80 <= 1'h1;
      pg_window_ok <= 1'h0;
      step(8);
      rd(`BFS_OFS_STATE, 32'h2);
      ob(32'h9, 32'h8);
      chk("pg_out", power_good_flag_out, 32'h0);
      fb_below_80 <= 1'h0;
      pg_window_ok <= 1'h1;
      step(4);
      wr(`BFS_OFS_CTRL, 32'h3);
      wr(`BFS_OFS_STATUS, 32'h3F);
      ls_request <= 1'h1;
      fb_above_102 <= 1'h1;
      fb_above_104 <= 1'h1;
      step(8);
      ob(32'hC, 32'h4);
      fb_above_104 <= 1'h0;
      step(8);
      rd(`BFS_OFS_STATE, 32'h4);
      fb_above_102 <= 1'h0;
      step(6);
      for (int i = 1; i <= 15; i++) begin
         forced_continuous_conduction_cycle_done <= 1'h1;
         step(3);
         forced_continuous_conduction_cycle_done <= 1'h0;
         step(4);
         if (i >= 14) rd(`BFS_OFS_STATE, i == 15 ? 32'h2 : 32'h4);
      end
      rd(`BFS_OFS_STATUS, 32'h8);
      wr(`BFS_OFS_STATUS, 32'h3F);
      fb_above_102 <= 1'h1;
      fb_above_104 <= 1'h1;
      fb_above_116 <= 1'h1;
      step(8);
      ob(32'hD, 32'h4);
      rd(`BFS_OFS_STATE, 32'h20);
      fb_above_102 <= 1'h0;
      fb_above_104 <= 1'h0;
      fb_above_116 <= 1'h0;
      step(8);
      ob(32'h9, 32'h0);
      neg;
      runlen(1, 1);
      runlen(1, 0);
      chk("ovp_pause", n, 32'h7);
      fb_below_50 <= 1'h1;
      step(6);
      neg;
      repeat (12) begin
         step(1);
         ob(32'h4, 32'h4);
      end
      fb_below_50 <= 1'h0;
      rd(`BFS_OFS_STATUS, 32'h12);
      wr(`BFS_OFS_STATUS, 32'h3F);
      enable_in <= 1'h0;
      step(10);
      rd(`BFS_OFS_STATE, 32'h1);
      enable_in <= 1'h1;
      step(10);
      rd(`BFS_OFS_STATE, 32'h2);
      temp_above_160 <= 1'h1;
      temp_cooled_30 <= 1'h0;
      step(8);
      ob(32'hE, 32'h2);
      temp_above_160 <= 1'h0;
      step(10);
      rd(`BFS_OFS_STATE, 32'h40);
      temp_cooled_30 <= 1'h1;
      step(10);
      rd(`BFS_OFS_STATE, 32'h40);
      enable_in <= 1'h0;
      step(10);
      enable_in <= 1'h1;
      step(10);
      rd(`BFS_OFS_STATE, 32'h2);
      ob(32'h2, 32'h0);
      rd(`BFS_OFS_STATUS, 32'h4);
      stop_test;
   end
endmodule // bfs_supervisor_test

/* File: design/bfs_pkg.sv */
// types shared by the fault protection supervisor
// assumes the offsets and timing figures come from bfs_regs.svh
package bfs_pkg;

   typedef enum logic [6:0] {
      BFS_ST_OFF = 7'h01,
      BFS_ST_RUN = 7'h02,
      BFS_ST_QDM = 7'h04,
      BFS_ST_HIC_OFF = 7'h08,
      BFS_ST_HIC_ON = 7'h10,
      BFS_ST_OVP = 7'h20,
      BFS_ST_OTP = 7'h40
   } bfs_state_t;

endpackage

/* File: design/bfs_regs.svh */
// register map, field positions, reset values and timing figures
// assumes a 10 MHz system clock and 32-bit byte-addressed register port
`ifndef BFS_REGS_SVH
`define BFS_REGS_SVH

`define BFS_ADDR_W 4
`define BFS_OFS_STATUS 4'h0
`define BFS_OFS_MASK 4'h4
`define BFS_OFS_STATE 4'h8
`define BFS_OFS_CTRL 4'hC

`define BFS_EV_W 6
`define BFS_EV_UVP 0
`define BFS_EV_OVP 1
`define BFS_EV_OTP 2
`define BFS_EV_QDM 3
`define BFS_EV_NEG 4
`define BFS_EV_VALLEY 5

`define BFS_CTRL_QDM_EN 0
`define BFS_CTRL_UVP_EN 1

`define BFS_MASK_RST 6'h00
`define BFS_CTRL_RST 2'h3

`define BFS_CLK_KHZ 10000
`define BFS_HIC_OFF_US 8500
`define BFS_HIC_ON_US 2400
`define BFS_NEG_PAUSE_NS 700
`define BFS_QDM_EXIT_CYCLES 15

`endif

/* File: design/bfs_supervisor.sv */
// fault protection supervisor: gates switch commands, hiccup, latch-offs, discharge
// assumes comparator levels from the analog front end and one 10 MHz clock
//
// Contract
// - Block new high-side pulse while low-side current is above valley limit.
// - Feedback below 80 percent turns off both switches, enters hiccup.
// - Hiccup stays off 8.5 ms, then retries for 2.4 ms.
// - Repeat hiccup while fault persists, resume regulation once gone.
// - Current below negative limit turns low side off for 700 ns.
// - Feedback above 116 percent latches high side off, power-good low.
// - In overvoltage latch, low side on until negative limit, then pause.
// - In overvoltage latch below 50 percent, low side stays continuously on.
// - Feedback above 104 but below 116 percent enters quick discharge.
// - Quick discharge: high off, low on with pauses until below 102 percent.
// - Leave quick discharge after 15 consecutive forced-continuous cycles.
// - Disabled by enable, lockout or overheating: switch node discharge on.
// - Discharge path released once the disabling condition has cleared.
// - Junction above 160 degrees stops all switching.
// - Overheat latch holds until cooled 30 degrees and enable restarted.
// - After start-up any protection event pulls power-good low; valley and negative-limit events during regulation leave it released.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "bfs_regs.svh"

module bfs_supervisor #(
   parameter int CLK_KHZ = `BFS_CLK_KHZ,
   parameter int HIC_OFF_CYC = (`BFS_HIC_OFF_US * CLK_KHZ) / 1000,
   parameter int HIC_ON_CYC = (`BFS_HIC_ON_US * CLK_KHZ) / 1000,
   parameter int NEG_PAUSE_CYC = (`BFS_NEG_PAUSE_NS * CLK_KHZ + 999999) / 1000000,
   parameter int QDM_EXIT_CYC = `BFS_QDM_EXIT_CYCLES,
   parameter int CNT_W = 17
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic enable_in,
   input wire logic vin_ok,
   input wire logic softstart_done,
   input wire logic pg_window_ok,
   input wire logic fb_below_50,
   input wire logic fb_below_80,
   input wire logic fb_above_102,
   input wire logic fb_above_104,
   input wire logic fb_above_116,
   input wire logic il_above_valley,
   input wire logic il_below_negative,
   input wire logic temp_above_160,
   input wire logic temp_cooled_30,
   input wire logic ton_request,
   input wire logic ls_request,
   input wire logic forced_continuous_conduction_cycle_done,
   input wire logic [`BFS_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   output logic hs_on,
   output logic ls_on,
   output logic discharge_on,
   output logic power_good_flag_out,
   output logic power_good_flag_oe_n
);

   localparam int NSYNC = 14;

   // comparator and control levels pass two flops before any use
   logic [NSYNC-1:0] sync_q;
   wire [NSYNC-1:0] raw_in = {enable_in, vin_ok, softstart_done, pg_window_ok,
      fb_below_50, fb_below_80, fb_above_102, fb_above_104, fb_above_116,
      il_above_valley, il_below_negative, temp_above_160, temp_cooled_30,
      forced_continuous_conduction_cycle_done};

   bfs_sync2 #(
      .W(NSYNC)
   ) u_sync (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .d(raw_in),
      .q(sync_q)
   );

   wire s_en = sync_q[13];
   wire s_vin = sync_q[12];
   wire s_ss_done = sync_q[11];
   wire s_pg_win = sync_q[10];
   wire s_fb_lt50 = sync_q[9];
   wire s_fb_lt80 = sync_q[8];
   wire s_fb_gt102 = sync_q[7];
   wire s_fb_gt104 = sync_q[6];
   wire s_fb_gt116 = sync_q[5];
   wire s_valley = sync_q[4];
   wire s_neg = sync_q[3];
   wire s_hot = sync_q[2];
   wire s_cooled = sync_q[1];
   wire s_forced_continuous_conduction_done = sync_q[0];

   bfs_pkg::bfs_state_t state;
   bfs_pkg::bfs_state_t next_state;
   logic [CNT_W-1:0] hic_cnt;
   logic [CNT_W-1:0] next_hic_cnt;
   logic [3:0] pause_cnt;
   logic [4:0] qdm_cnt;
   logic qdm_draining;
   logic ov_low;
   logic otp_cool;
   logic [`BFS_EV_W-1:0] status;
   logic [`BFS_EV_W-1:0] mask;
   logic [1:0] ctrl;

   wire enabled = s_en && s_vin;
   wire uvp_armed = ctrl[`BFS_CTRL_UVP_EN] && s_ss_done;
   wire qdm_allowed = ctrl[`BFS_CTRL_QDM_EN];
   wire hic_done = (hic_cnt == '0);
   wire in_pause = (pause_cnt != 4'h0);
   wire [CNT_W-1:0] hic_off_load = CNT_W'(HIC_OFF_CYC - 1);
   wire [CNT_W-1:0] hic_on_load = CNT_W'(HIC_ON_CYC - 1);
   wire [4:0] qdm_last = 5'(QDM_EXIT_CYC);
   // loaded one short: the output register already adds the first off cycle
   wire [3:0] pause_load = 4'(NEG_PAUSE_CYC - 1);

   // sequencing; disabling wins over everything except the heat latch
   always_comb begin
      next_state = state;
      next_hic_cnt = (hic_cnt == '0) ? hic_cnt : hic_cnt - CNT_W'(1);
      case (state)
         bfs_pkg::BFS_ST_OFF: begin
            if (s_hot)
               next_state = bfs_pkg::BFS_ST_OTP;
            else if (enabled)
               next_state = bfs_pkg::BFS_ST_RUN;
         end
         bfs_pkg::BFS_ST_RUN, bfs_pkg::BFS_ST_QDM, bfs_pkg::BFS_ST_HIC_ON: begin
            if (s_hot) begin
               next_state = bfs_pkg::BFS_ST_OTP;
            end else if (!enabled) begin
               next_state = bfs_pkg::BFS_ST_OFF;
            end else if (s_fb_gt116) begin
               next_state = bfs_pkg::BFS_ST_OVP;
            end else if (state == bfs_pkg::BFS_ST_HIC_ON) begin
               if (hic_done) begin
                  if (s_fb_lt80) begin
                     next_state = bfs_pkg::BFS_ST_HIC_OFF;
                     next_hic_cnt = hic_off_load;
                  end else begin
                     next_state = bfs_pkg::BFS_ST_RUN;
                  end
               end
            end else if (uvp_armed && s_fb_lt80) begin
               next_state = bfs_pkg::BFS_ST_HIC_OFF;
               next_hic_cnt = hic_off_load;
            end else if (state == bfs_pkg::BFS_ST_RUN) begin
               if (qdm_allowed && s_fb_gt104)
                  next_state = bfs_pkg::BFS_ST_QDM;
            end else if (!qdm_draining && qdm_cnt == qdm_last) begin
               next_state = bfs_pkg::BFS_ST_RUN;
            end
         end
         bfs_pkg::BFS_ST_HIC_OFF: begin
            if (s_hot) begin
               next_state = bfs_pkg::BFS_ST_OTP;
            end else if (!enabled) begin
               next_state = bfs_pkg::BFS_ST_OFF;
            end else if (hic_done) begin
               next_state = bfs_pkg::BFS_ST_HIC_ON;
               next_hic_cnt = hic_on_load;
            end
         end
         bfs_pkg::BFS_ST_OVP: begin
            if (s_hot)
               next_state = bfs_pkg::BFS_ST_OTP;
            else if (!enabled)
               next_state = bfs_pkg::BFS_ST_OFF;
         end
         bfs_pkg::BFS_ST_OTP: begin
            // restart needs cooling and then a fresh enable or supply cycle
            if (otp_cool && !enabled && !s_hot)
               next_state = bfs_pkg::BFS_ST_OFF;
         end
         default: next_state = bfs_pkg::BFS_ST_OFF;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= bfs_pkg::BFS_ST_OFF;
         hic_cnt <= '0;
      end else begin
         state <= next_state;
         hic_cnt <= next_hic_cnt;
      end
   end

   // latches kept beside the state: heat cool-down and deep overvoltage
   wire entering_ovp = (next_state == bfs_pkg::BFS_ST_OVP) && (state != bfs_pkg::BFS_ST_OVP);
   wire entering_otp = (next_state == bfs_pkg::BFS_ST_OTP) && (state != bfs_pkg::BFS_ST_OTP);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         ov_low <= 1'b0;
      else if (entering_ovp)
         ov_low <= 1'b0;
      else if (state == bfs_pkg::BFS_ST_OVP && s_fb_lt50)
         ov_low <= 1'b1;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         otp_cool <= 1'b0;
      else if (entering_otp)
         otp_cool <= 1'b0;
      else if (state == bfs_pkg::BFS_ST_OTP && s_cooled)
         otp_cool <= 1'b1;
   end

   // quick discharge drains to 102 percent, then counts continuous cycles
   wire entering_qdm = (next_state == bfs_pkg::BFS_ST_QDM) && (state != bfs_pkg::BFS_ST_QDM);

   // count pulses, not cycles: a done pulse several clocks wide counts once
   logic forced_continuous_conduction_prev;
   wire forced_continuous_conduction_rise = s_forced_continuous_conduction_done && !forced_continuous_conduction_prev;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         forced_continuous_conduction_prev <= 1'b0;
      else
         forced_continuous_conduction_prev <= s_forced_continuous_conduction_done;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         qdm_draining <= 1'b0;
         qdm_cnt <= 5'h00;
      end else if (entering_qdm) begin
         qdm_draining <= 1'b1;
         qdm_cnt <= 5'h00;
      end else if (state == bfs_pkg::BFS_ST_QDM) begin
         if (qdm_draining && !s_fb_gt102)
            qdm_draining <= 1'b0;
         else if (!qdm_draining && s_fb_gt104)
            qdm_draining <= 1'b1;
         if (qdm_draining)
            qdm_cnt <= 5'h00;
         else if (forced_continuous_conduction_rise && qdm_cnt != qdm_last)
            qdm_cnt <= qdm_cnt + 5'h01;
      end
   end

   // negative-limit pause, shared by every low-side mode but the deep-overvoltage latch
   wire neg_hit = ls_on && s_neg && !in_pause;
   wire pause_exempt = (state == bfs_pkg::BFS_ST_OVP) && ov_low;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         pause_cnt <= 4'h0;
      else if (neg_hit && !pause_exempt)
         pause_cnt <= pause_load;
      else if (in_pause)
         pause_cnt <= pause_cnt - 4'h1;
   end

   // switch commands
   wire normal_sw = (state == bfs_pkg::BFS_ST_RUN) || (state == bfs_pkg::BFS_ST_HIC_ON) ||
      (state == bfs_pkg::BFS_ST_QDM && !qdm_draining);
   wire forced_ls = (state == bfs_pkg::BFS_ST_OVP) ||
      (state == bfs_pkg::BFS_ST_QDM && qdm_draining);
   // a pulse already running finishes; only a new start waits for the valley
   wire next_hs = normal_sw && ton_request && (hs_on || !s_valley);
   wire next_ls = pause_exempt ? 1'b1 :
      (forced_ls ? !in_pause && !(neg_hit) :
      (normal_sw && ls_request && !next_hs && !in_pause && !neg_hit));
   wire next_discharge = (state == bfs_pkg::BFS_ST_OFF) || (state == bfs_pkg::BFS_ST_OTP);
   wire pg_release = (state == bfs_pkg::BFS_ST_RUN) && s_ss_done && s_pg_win;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hs_on <= 1'b0;
         ls_on <= 1'b0;
      end else begin
         hs_on <= next_hs;
         ls_on <= next_ls;
      end
   end

   // open drain: only the enable moves, the driven level stays low
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         discharge_on <= 1'b0;
         power_good_flag_out <= 1'b0;
         power_good_flag_oe_n <= 1'b0;
      end else begin
         discharge_on <= next_discharge;
         power_good_flag_out <= 1'b0;
         power_good_flag_oe_n <= pg_release;
      end
   end

   // event capture for software
   wire [`BFS_EV_W-1:0] ev;
   assign ev[`BFS_EV_UVP] = (next_state == bfs_pkg::BFS_ST_HIC_OFF) &&
      (state != bfs_pkg::BFS_ST_HIC_OFF);
   assign ev[`BFS_EV_OVP] = entering_ovp;
   assign ev[`BFS_EV_OTP] = entering_otp;
   assign ev[`BFS_EV_QDM] = entering_qdm;
   assign ev[`BFS_EV_NEG] = neg_hit && !pause_exempt;
   assign ev[`BFS_EV_VALLEY] = normal_sw && ton_request && !hs_on && s_valley;

   wire hit_status = (reg_addr == `BFS_OFS_STATUS);
   wire hit_mask = (reg_addr == `BFS_OFS_MASK);
   wire hit_state = (reg_addr == `BFS_OFS_STATE);
   wire hit_ctrl = (reg_addr == `BFS_OFS_CTRL);
   wire [`BFS_EV_W-1:0] w1c = (reg_wr && hit_status) ? reg_wdata[`BFS_EV_W-1:0] : '0;
   // a fresh event outranks a clear arriving in the same cycle
   wire [`BFS_EV_W-1:0] next_status = (status & ~w1c) | ev;
   wire [31:0] rd_mux = hit_status ? {26'h0, status} :
      hit_mask ? {26'h0, mask} :
      hit_state ? {25'h0, state} :
      hit_ctrl ? {30'h0, ctrl} : 32'h0;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         status <= '0;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         irq <= |(next_status & mask);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mask <= `BFS_MASK_RST;
         ctrl <= `BFS_CTRL_RST;
      end else begin
         if (reg_wr && hit_mask)
            mask <= reg_wdata[`BFS_EV_W-1:0];
         if (reg_wr && hit_ctrl)
            ctrl <= reg_wdata[1:0];
      end
   end

   // read data stand for one cycle only, zero otherwise
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         reg_rdata <= 32'h0;
      else
         reg_rdata <= reg_rd ? rd_mux : 32'h0;
   end

endmodule // bfs_supervisor

// two-flop synchroniser for a bundle of level inputs
module bfs_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule // bfs_sync2
